// ==== inc/dcf_map.svh ====
// Constants for the deep FIFO status-flag block
`ifndef DCF_MAP_SVH
`define DCF_MAP_SVH

`define DCF_DATA_W          18
`define DCF_DEPTH_SMALL     131072
`define DCF_DEPTH_LARGE     262144
`define DCF_STAGE_DEPTH     8
`define DCF_PART_W          9
`define DCF_OFS_SERIAL_DEF  18'h0_03FF
`define DCF_OFS_PARALL_DEF  18'h0_007F
`define DCF_FULL_STAGES     2
`define DCF_EMPTY_STAGES    2
`define DCF_READY_STAGES    3
`define DCF_FT_LATENCY      3

`endif

// ==== inc/dcf_pkg.sv ====
// Types for the deep FIFO status-flag block
package dcf_pkg;
    typedef enum logic [1:0] {
        OFS_EMPTY_LO,
        OFS_EMPTY_HI,
        OFS_FULL_LO,
        OFS_FULL_HI
    } dcf_part_t;
endpackage

// ==== logic/dcf_stage_fifo.sv ====
// Small valid/ready staging FIFO in front of the deep memory
`timescale 1ns/1ps
`default_nettype none
module dcf_stage_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 8
) (
    input  wire logic             CLK_I,        // Core clock
    input  wire logic             RESET_I,      // Sync reset, high
    input  wire logic             IN_VALID_I,   // Word offered
    output logic                  IN_READY_O,   // Room for a word
    input  wire logic [WIDTH-1:0] IN_DATA_I,    // Word in
    output logic                  OUT_VALID_O,  // Word available
    input  wire logic             OUT_READY_I,  // Drain accepts
    output logic      [WIDTH-1:0] OUT_DATA_O    // Word out
);
    localparam int PTR_W = $clog2(DEPTH);

    initial begin
        if (DEPTH < 2 || (1 << PTR_W) != DEPTH) begin
            $error("Staging depth must be a power of two, at least 2");
        end
    end

    logic [WIDTH-1:0] store_reg [DEPTH];
    logic [PTR_W-1:0] wr_ptr_reg;
    logic [PTR_W-1:0] rd_ptr_reg;
    logic [PTR_W:0]   count_reg;
    logic             push;
    logic             pop;

    assign IN_READY_O  = count_reg != (PTR_W+1)'(DEPTH);
    assign OUT_VALID_O = count_reg != '0;
    assign OUT_DATA_O  = store_reg[rd_ptr_reg];
    assign push        = IN_VALID_I && IN_READY_O;
    assign pop         = OUT_VALID_O && OUT_READY_I;

    always_ff @(posedge CLK_I) begin
        if (push) begin
            store_reg[wr_ptr_reg] <= IN_DATA_I;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ==== logic/dcf_top.sv ====
// Deep FIFO with standard / fall-through status flags and offset loading
// What this block does
// - Mode strap caught during reset selects timing
// - Standard mode: every word needs a read
// - Fall-through: first word appears after three edges
// - Write enable low stores the data word
// - Empty flag tracks first write, last read
// - Standard almost-empty high above n words
// - Standard half-full low from half plus one
// - Standard almost-full low from depth minus m
// - Full flag low at depth, blocks writes
// - Standard empty and full: two register stages
// - Output-ready low with data, reads blocked empty
// - Fall-through almost-empty high above n+1 words
// - Fall-through half-full low from half plus two
// - Fall-through almost-full low from depth+1-m
// - Fall-through capacity depth+1, input-ready blocks writes
// - Output-ready three stages, input-ready two stages
// - Load strap high: serial loading, offsets 3FF
// - Load strap low: parallel loading, offsets 07F
// - Offsets read back only by parallel read
// - Offsets reprogrammable any time after reset
// - Serial load shifts one bit per edge
// - Parallel load walks four parts, then wraps
// - Separate load and read-back pointers, reset to start
`timescale 1ns/1ps
`default_nettype none
`include "dcf_map.svh"
module dcf_top
    import dcf_pkg::*;
#(
    parameter int DEPTH       = `DCF_DEPTH_SMALL,
    parameter int STAGE_DEPTH = `DCF_STAGE_DEPTH
) (
    input  wire logic                  CORE_CLK_I,                      // Core clock
    input  wire logic                  RESET_I,                         // Master reset
    input  wire logic                  WRITE_EN_N_I,                    // Write enable, low
    input  wire logic                  READ_EN_N_I,                     // Read enable, low
    input  wire logic [`DCF_DATA_W-1:0] DATA_IN_I,                      // Data in
    input  wire logic                  OFFSET_LOAD_N_I,                 // Offset access, low
    input  wire logic                  SERIAL_ENABLE_N_I,               // Serial shift, low
    input  wire logic                  FALL_THROUGH_SELECT_SERIAL_IN_I, // Strap / serial bit
    output logic      [`DCF_DATA_W-1:0] DATA_OUT_O,                     // Data out
    output logic                       EMPTY_FLAG_N_O,                  // Empty / output-ready
    output logic                       FULL_FLAG_N_O,                   // Full / input-ready
    output logic                       ALMOST_EMPTY_N_O,                // Almost empty, low
    output logic                       ALMOST_FULL_N_O,                 // Almost full, low
    output logic                       HALF_FULL_N_O,                   // Half full, low
    output logic                       FALL_THROUGH_MODE_O              // Timing mode caught
);
    localparam int DATA_W = `DCF_DATA_W;
    localparam int PART_W = `DCF_PART_W;
    localparam int ADDR_W = $clog2(DEPTH);
    localparam int OFS_W  = ADDR_W;
    localparam int LVL_W  = $clog2(DEPTH + 2);
    localparam int CMP_W  = LVL_W + 1;

    initial begin
        if ((1 << ADDR_W) != DEPTH || OFS_W <= PART_W || OFS_W > 2 * PART_W) begin
            $error("Depth must be a power of two between 2**10 and 2**18");
        end
    end

    function automatic logic [2*OFS_W-1:0] put_part(input logic [2*OFS_W-1:0] ofs,
                                                   input dcf_part_t part,
                                                   input logic [DATA_W-1:0] d);
        logic [2*OFS_W-1:0] r;
        r = ofs;
        unique case (part)
            OFS_EMPTY_LO: r[PART_W-1:0]               = d[PART_W-1:0];
            OFS_EMPTY_HI: r[OFS_W-1:PART_W]           = d[OFS_W-PART_W-1:0];
            OFS_FULL_LO:  r[OFS_W+PART_W-1:OFS_W]     = d[PART_W-1:0];
            OFS_FULL_HI:  r[2*OFS_W-1:OFS_W+PART_W]   = d[OFS_W-PART_W-1:0];
        endcase
        return r;
    endfunction

    function automatic logic [DATA_W-1:0] get_part(input logic [2*OFS_W-1:0] ofs,
                                                  input dcf_part_t part);
        logic [DATA_W-1:0] r;
        r = '0;
        unique case (part)
            OFS_EMPTY_LO: r[PART_W-1:0]       = ofs[PART_W-1:0];
            OFS_EMPTY_HI: r[OFS_W-PART_W-1:0] = ofs[OFS_W-1:PART_W];
            OFS_FULL_LO:  r[PART_W-1:0]       = ofs[OFS_W+PART_W-1:OFS_W];
            OFS_FULL_HI:  r[OFS_W-PART_W-1:0] = ofs[2*OFS_W-1:OFS_W+PART_W];
        endcase
        return r;
    endfunction

    function automatic dcf_part_t next_part(input dcf_part_t part);
        dcf_part_t r;
        r = OFS_EMPTY_LO;
        unique case (part)
            OFS_EMPTY_LO: r = OFS_EMPTY_HI;
            OFS_EMPTY_HI: r = OFS_FULL_LO;
            OFS_FULL_LO:  r = OFS_FULL_HI;
            OFS_FULL_HI:  r = OFS_EMPTY_LO;
        endcase
        return r;
    endfunction

    logic                 fall_through_mode_reg;
    logic                 serial_mode_reg;
    logic [2*OFS_W-1:0]   ofs_reg;
    dcf_part_t            wr_part_reg;
    dcf_part_t            rd_part_reg;
    logic [DATA_W-1:0]    mem [DEPTH];
    logic [ADDR_W-1:0]    mem_wptr_reg;
    logic [ADDR_W-1:0]    mem_rptr_reg;
    logic [ADDR_W:0]      mem_cnt_reg;
    logic [LVL_W-1:0]     level_reg;
    logic [LVL_W-1:0]     level_next;
    logic                 out_valid_reg;
    logic [1:0]           empty_pipe_reg;
    logic                 full_pipe_reg;
    logic                 stg_in_ready;
    logic                 stg_out_valid;
    logic                 stg_out_ready;
    logic [DATA_W-1:0]    stg_out_data;
    logic [LVL_W-1:0]     cap;
    logic                 full_raw;
    logic                 wr_take;
    logic                 rd_take_std;
    logic                 rd_take_ft;
    logic                 load_out;
    logic                 mem_push;
    logic                 mem_pop;
    logic                 consume;
    logic                 ofs_wr;
    logic                 ofs_rd;
    logic                 ofs_shift;
    logic [CMP_W-1:0]     lvl_x;
    logic [CMP_W-1:0]     n_x;
    logic [CMP_W-1:0]     m_x;
    logic                 empty_raw_n;
    logic                 full_raw_pin;
    logic                 ae_raw_n;
    logic                 hf_raw_n;
    logic                 af_raw_n;

    // Command decode
    assign cap          = fall_through_mode_reg ? LVL_W'(DEPTH + 1) : LVL_W'(DEPTH);
    assign full_raw     = level_reg == cap;
    assign wr_take      = OFFSET_LOAD_N_I && !WRITE_EN_N_I && !full_raw && stg_in_ready;
    assign rd_take_std  = !fall_through_mode_reg && OFFSET_LOAD_N_I && !READ_EN_N_I
                          && level_reg != '0 && mem_cnt_reg != '0;
    assign rd_take_ft   = fall_through_mode_reg && OFFSET_LOAD_N_I && !READ_EN_N_I && out_valid_reg;
    assign load_out     = fall_through_mode_reg && mem_cnt_reg != '0 && (!out_valid_reg || rd_take_ft);
    assign mem_pop      = rd_take_std || load_out;
    assign consume      = rd_take_std || rd_take_ft;
    assign stg_out_ready = mem_cnt_reg != (ADDR_W+1)'(DEPTH);
    assign mem_push     = stg_out_valid && stg_out_ready;
    assign ofs_wr       = !serial_mode_reg && !OFFSET_LOAD_N_I && !WRITE_EN_N_I;
    assign ofs_rd       = !OFFSET_LOAD_N_I && !READ_EN_N_I && WRITE_EN_N_I;
    assign ofs_shift    = serial_mode_reg && !OFFSET_LOAD_N_I && !SERIAL_ENABLE_N_I
                          && WRITE_EN_N_I;
    assign level_next   = level_reg + LVL_W'(wr_take) - LVL_W'(consume);

    dcf_stage_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (STAGE_DEPTH)
    ) u_stage (
        .CLK_I       (CORE_CLK_I),
        .RESET_I     (RESET_I),
        .IN_VALID_I  (wr_take),
        .IN_READY_O  (stg_in_ready),
        .IN_DATA_I   (DATA_IN_I),
        .OUT_VALID_O (stg_out_valid),
        .OUT_READY_I (stg_out_ready),
        .OUT_DATA_O  (stg_out_data)
    );

    // Mode straps, sampled while reset is held
    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            fall_through_mode_reg        <= FALL_THROUGH_SELECT_SERIAL_IN_I;
            serial_mode_reg <= OFFSET_LOAD_N_I;
        end
    end

    // Offset registers and their pointers
    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            ofs_reg     <= OFFSET_LOAD_N_I
                         ? {2{OFS_W'(`DCF_OFS_SERIAL_DEF)}}
                         : {2{OFS_W'(`DCF_OFS_PARALL_DEF)}};
            wr_part_reg <= OFS_EMPTY_LO;
            rd_part_reg <= OFS_EMPTY_LO;
        end else begin
            if (ofs_shift) begin
                ofs_reg <= {FALL_THROUGH_SELECT_SERIAL_IN_I, ofs_reg[2*OFS_W-1:1]};
            end else if (ofs_wr) begin
                ofs_reg     <= put_part(ofs_reg, wr_part_reg, DATA_IN_I);
                wr_part_reg <= next_part(wr_part_reg);
            end
            if (ofs_rd) begin
                rd_part_reg <= next_part(rd_part_reg);
            end
        end
    end

    // Deep memory
    always_ff @(posedge CORE_CLK_I) begin
        if (mem_push) begin
            mem[mem_wptr_reg] <= stg_out_data;
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            mem_wptr_reg <= '0;
            mem_rptr_reg <= '0;
            mem_cnt_reg  <= '0;
        end else begin
            if (mem_push) begin
                mem_wptr_reg <= mem_wptr_reg + 1'b1;
            end
            if (mem_pop) begin
                mem_rptr_reg <= mem_rptr_reg + 1'b1;
            end
            if (mem_push && !mem_pop) begin
                mem_cnt_reg <= mem_cnt_reg + 1'b1;
            end else if (mem_pop && !mem_push) begin
                mem_cnt_reg <= mem_cnt_reg - 1'b1;
            end
        end
    end

    // Fill level counts every word held, output register included
    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            level_reg     <= '0;
            out_valid_reg <= 1'b0;
        end else begin
            level_reg <= level_next;
            if (load_out) begin
                out_valid_reg <= 1'b1;
            end else if (rd_take_ft) begin
                out_valid_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            DATA_OUT_O <= '0;
        end else if (mem_pop) begin
            DATA_OUT_O <= mem[mem_rptr_reg];
        end else if (ofs_rd) begin
            DATA_OUT_O <= get_part(ofs_reg, rd_part_reg);
        end
    end

    // Raw flags from the fill level; fall-through output-ready from the output register
    assign lvl_x        = CMP_W'(level_reg);
    assign n_x          = CMP_W'(ofs_reg[OFS_W-1:0]);
    assign m_x          = CMP_W'(ofs_reg[2*OFS_W-1:OFS_W]);
    assign empty_raw_n  = fall_through_mode_reg ? !out_valid_reg : (level_reg != '0);
    assign full_raw_pin = fall_through_mode_reg ? full_raw : !full_raw;
    assign ae_raw_n     = fall_through_mode_reg ? (lvl_x > n_x + CMP_W'(1)) : (lvl_x > n_x);
    assign hf_raw_n     = fall_through_mode_reg ? (lvl_x < CMP_W'(DEPTH / 2 + 2))
                                   : (lvl_x < CMP_W'(DEPTH / 2 + 1));
    assign af_raw_n     = fall_through_mode_reg ? (lvl_x + m_x < CMP_W'(DEPTH + 1))
                                   : (lvl_x + m_x < CMP_W'(DEPTH));

    // Flag output stages
    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            empty_pipe_reg <= {2{FALL_THROUGH_SELECT_SERIAL_IN_I}};
            EMPTY_FLAG_N_O <= FALL_THROUGH_SELECT_SERIAL_IN_I;
        end else begin
            empty_pipe_reg <= {empty_pipe_reg[0], empty_raw_n};
            EMPTY_FLAG_N_O <= fall_through_mode_reg ? empty_pipe_reg[1] : empty_pipe_reg[0];
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            full_pipe_reg <= !FALL_THROUGH_SELECT_SERIAL_IN_I;
            FULL_FLAG_N_O <= !FALL_THROUGH_SELECT_SERIAL_IN_I;
        end else begin
            full_pipe_reg <= full_raw_pin;
            FULL_FLAG_N_O <= full_pipe_reg;
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            ALMOST_EMPTY_N_O    <= 1'b0;
            ALMOST_FULL_N_O     <= 1'b1;
            HALF_FULL_N_O       <= 1'b1;
            FALL_THROUGH_MODE_O <= FALL_THROUGH_SELECT_SERIAL_IN_I;
        end else begin
            ALMOST_EMPTY_N_O    <= ae_raw_n;
            ALMOST_FULL_N_O     <= af_raw_n;
            HALF_FULL_N_O       <= hf_raw_n;
            FALL_THROUGH_MODE_O <= fall_through_mode_reg;
        end
    end

    // Checks
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (RESET_I);

    logic lvl_zero;
    assign lvl_zero = level_reg == '0;

    full_blocks_a: assert property (full_raw && !consume |=> level_reg == cap)
        else $error("Write accepted while full");
    empty_ignore_a: assert property (!fall_through_mode_reg && lvl_zero && OFFSET_LOAD_N_I |=>
        $stable(DATA_OUT_O) && lvl_zero || level_reg == LVL_W'(1))
        else $error("Read taken while empty");
    empty_stage_a: assert property (!fall_through_mode_reg |-> ##2 EMPTY_FLAG_N_O == $past(!lvl_zero, 2))
        else $error("Empty flag not two stages behind level");
    ready_stage_a: assert property (fall_through_mode_reg |-> ##3 EMPTY_FLAG_N_O == $past(!out_valid_reg, 3))
        else $error("Output-ready not three stages behind");
    full_stage_a: assert property (##2 FULL_FLAG_N_O == $past(full_raw_pin, 2))
        else $error("Full flag not two stages behind");
    fall_through_a: assert property (fall_through_mode_reg && lvl_zero && wr_take |-> ##3 out_valid_reg)
        else $error("First word did not fall through in three edges");
    almost_empty_a: assert property (!fall_through_mode_reg && lvl_x == n_x + CMP_W'(1) |=> ALMOST_EMPTY_N_O)
        else $error("Almost-empty wrong at n+1");
    half_full_a: assert property (!fall_through_mode_reg && lvl_x == CMP_W'(DEPTH / 2 + 1) |=> !HALF_FULL_N_O)
        else $error("Half-full not low at half plus one");
    almost_full_a: assert property (fall_through_mode_reg && lvl_x + m_x == CMP_W'(DEPTH) |=> ALMOST_FULL_N_O)
        else $error("Almost-full low one word early");
    offset_default_a: assert property ($fell(RESET_I) |-> ofs_reg == (serial_mode_reg
        ? {2{OFS_W'(`DCF_OFS_SERIAL_DEF)}} : {2{OFS_W'(`DCF_OFS_PARALL_DEF)}}))
        else $error("Offset defaults wrong after reset");

    first_word_c: cover property (fall_through_mode_reg && lvl_zero && wr_take ##3 out_valid_reg);
    full_reach_c: cover property (!FULL_FLAG_N_O && !fall_through_mode_reg);
    part_wrap_c:  cover property (ofs_wr && wr_part_reg == OFS_FULL_HI);
endmodule
`default_nettype wire

// ==== tb/dcf_top_bench.sv ====
// Self-checking bench for the deep FIFO status flags
`timescale 1ns/1ps
`default_nettype none
`include "dcf_map.svh"
module dcf_top_bench;
    localparam int DEPTH = 1024;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    wire logic   wen_n, ren_n, ld_n, sen_n, si, ef, ff, ae, af, hf, mode;
    wire logic [17:0] din;
    wire logic [17:0] dout;
    wire logic [17:0] flg = {12'h000, ef, ff, ae, af, hf, mode};
    int          n_mismatch = 0;
    int          check_count = 0;
    int          lvl = 0;
    int          cyc = 0;
    logic [17:0] d;
    int          pw[5] = '{5, 0, 3, 0, 6};

    always #2.5 clk = ~clk;

    dcf_top #(.DEPTH(DEPTH), .STAGE_DEPTH(8)) dut (
        .CORE_CLK_I(clk), .RESET_I(rst), .WRITE_EN_N_I(wen_n), .READ_EN_N_I(ren_n),
        .DATA_IN_I(din), .OFFSET_LOAD_N_I(ld_n), .SERIAL_ENABLE_N_I(sen_n),
        .FALL_THROUGH_SELECT_SERIAL_IN_I(si), .DATA_OUT_O(dout), .EMPTY_FLAG_N_O(ef),
        .FULL_FLAG_N_O(ff), .ALMOST_EMPTY_N_O(ae), .ALMOST_FULL_N_O(af),
        .HALF_FULL_N_O(hf), .FALL_THROUGH_MODE_O(mode));

    dcf_user_model u_model (
        .clk_i(clk), .dout_i(dout), .wen_n_o(wen_n), .ren_n_o(ren_n), .din_o(din),
        .ld_n_o(ld_n), .sen_n_o(sen_n), .si_o(si));

    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            final_report();
        end
    end

    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic settle();
        repeat (5) @(posedge clk);
        #1;
    endtask
    task automatic do_reset(input logic ft, input logic ser);
        @(posedge clk);
        #1;
        u_model.strap(ft, ser);
        rst = 1'b1;
        repeat (8) @(posedge clk);
        #1;
        rst = 1'b0;
        lvl = 0;
    endtask
    task automatic fill(input int target);
        if (target > lvl)
            u_model.wr_seq(lvl, target - lvl);
        lvl = target;
    endtask
    // Flags one word below a threshold, then at it
    task automatic step(input int target, input logic [17:0] b, input logic [17:0] a);
        fill(target - 1);
        settle();
        chk(flg, b);
        fill(target);
        settle();
        chk(flg, a);
    endtask
    task automatic drain(input int first, input int cnt, input logic ft);
        logic [17:0] v;
        for (int k = first; k < first + cnt; k++) begin
            if (ft)
                chk(dout, u_model.wd(k));
            u_model.rd(v);
            if (!ft)
                chk(v, u_model.wd(k));
        end
        lvl = 0;
    endtask
    task automatic rb_check(input logic [17:0] a, b, c, e);
        logic [17:0] exp[4];
        logic [17:0] v;
        exp = '{a, b, c, e};
        for (int p = 0; p < 5; p++) begin
            u_model.ofs_rd(v);
            chk(v, exp[p % 4]);
        end
    endtask

    initial begin
        // Standard mode, parallel offsets
        do_reset(1'b0, 1'b0);
        chk(flg, 18'h0_0016);
        u_model.rd(d);
        chk(d, 18'h0_0000);
        rb_check(18'h0_007F, 18'h0_0000, 18'h0_007F, 18'h0_0000);
        step(1, 18'h0_0016, 18'h0_0036);
        step(128, 18'h0_0036, 18'h0_003E);
        step(513, 18'h0_003E, 18'h0_003C);
        step(897, 18'h0_003C, 18'h0_0038);
        step(DEPTH, 18'h0_0038, 18'h0_0028);
        u_model.wr_seq(DEPTH, 1);
        u_model.rd(d);
        chk(d, u_model.wd(0));
        settle();
        chk(flg, 18'h0_0038);
        drain(1, DEPTH - 1, 1'b0);
        settle();
        chk(flg, 18'h0_0016);
        $display("test standard fill and drain done");
        foreach (pw[i])
            u_model.ofs_wr(18'(pw[i]));
        // Read-back pointer kept its place: five reads left it on empty hi
        rb_check(18'h0_0000, 18'h0_0003, 18'h0_0000, 18'h0_0006);
        step(7, 18'h0_0036, 18'h0_003E);
        $display("test parallel offsets done");
        // Fall-through mode, serial offsets
        do_reset(1'b1, 1'b1);
        chk(flg, 18'h0_0027);
        rb_check(18'h0_01FF, 18'h0_0001, 18'h0_01FF, 18'h0_0001);
        u_model.wr_seq(0, 1);
        lvl = 1;
        repeat (2) @(posedge clk);
        #1;
        chk(dout, u_model.wd(0));
        settle();
        chk(flg, 18'h0_0007);
        step(2, 18'h0_0007, 18'h0_0003);
        step(514, 18'h0_0003, 18'h0_0001);
        step(DEPTH + 1, 18'h0_0001, 18'h0_0019);
        u_model.wr_seq(DEPTH + 1, 1);
        u_model.rd(d);
        settle();
        chk(flg, 18'h0_0001);
        drain(1, DEPTH, 1'b1);
        settle();
        chk(flg, 18'h0_0027);
        $display("test fall-through fill and drain done");
        do_reset(1'b1, 1'b1);
        u_model.ser_load(36'h0_0000_1404, 20);
        rb_check(18'h0_0004, 18'h0_0000, 18'h0_0005, 18'h0_0000);
        step(6, 18'h0_0007, 18'h0_000F);
        $display("test serial offsets done");
        final_report();
    end
endmodule
`default_nettype wire

// ==== tb/dcf_user_model.sv ====
// Writer and reader model driving the FIFO user pins
`timescale 1ns/1ps
`default_nettype none
`include "dcf_map.svh"
module dcf_user_model (
    input  wire logic                   clk_i,   // Core clock
    input  wire logic [`DCF_DATA_W-1:0] dout_i,  // Data out
    output logic                        wen_n_o, // Write enable, low
    output logic                        ren_n_o, // Read enable, low
    output logic      [`DCF_DATA_W-1:0] din_o,   // Data or offset part
    output logic                        ld_n_o,  // Offset access, low
    output logic                        sen_n_o, // Serial shift, low
    output logic                        si_o     // Strap or serial bit
);
    initial begin
        wen_n_o = 1'b1;
        ren_n_o = 1'b1;
        din_o   = 18'h0_0000;
        ld_n_o  = 1'b1;
        sen_n_o = 1'b1;
        si_o    = 1'b0;
    end
    function automatic logic [`DCF_DATA_W-1:0] wd(input int i);
        return 18'(i) ^ 18'h2_A5A5;
    endfunction
    // Released data bus shows the inverse of its last value
    task automatic release_bus();
        wen_n_o = 1'b1;
        ren_n_o = 1'b1;
        ld_n_o  = 1'b1;
        sen_n_o = 1'b1;
        din_o   = ~din_o;
        @(posedge clk_i);
        #1;
    endtask
    task automatic strap(input logic ft, input logic ser);
        si_o   = ft;
        ld_n_o = ser;
    endtask
    task automatic wr_seq(input int first, input int cnt);
        for (int i = 0; i < cnt; i++) begin
            ld_n_o  = 1'b1;
            wen_n_o = 1'b0;
            din_o   = wd(first + i);
            @(posedge clk_i);
            #1;
        end
        release_bus();
    endtask
    task automatic rd(output logic [`DCF_DATA_W-1:0] d);
        ld_n_o  = 1'b1;
        ren_n_o = 1'b0;
        @(posedge clk_i);
        #1;
        d = dout_i;
        release_bus();
    endtask
    task automatic ofs_wr(input logic [`DCF_DATA_W-1:0] v);
        ld_n_o  = 1'b0;
        wen_n_o = 1'b0;
        din_o   = v;
        @(posedge clk_i);
        #1;
        release_bus();
    endtask
    task automatic ofs_rd(output logic [`DCF_DATA_W-1:0] d);
        ld_n_o  = 1'b0;
        ren_n_o = 1'b0;
        @(posedge clk_i);
        #1;
        d = dout_i;
        release_bus();
    endtask
    task automatic ser_load(input logic [35:0] bits, input int cnt);
        ld_n_o  = 1'b0;
        sen_n_o = 1'b0;
        for (int i = 0; i < cnt; i++) begin
            si_o = bits[i];
            @(posedge clk_i);
            #1;
        end
        release_bus();
    endtask
endmodule
`default_nettype wire
